//--- i2cm_cfg.svh
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH

// Register byte offsets on the APB.
`define I2CM_OFS_CTRL1   12'h000
`define I2CM_OFS_CTRL2   12'h004
`define I2CM_OFS_STATUS  12'h008
`define I2CM_OFS_BUF     12'h00c
`define I2CM_OFS_RATE    12'h010
`define I2CM_OFS_FLAGS   12'h014

// Control register one fields.
`define I2CM_C1_EN       5
`define I2CM_C1_MODE_LO  0
`define I2CM_MODE_MASTER 4'h8

// Control register two fields.
`define I2CM_C2_SEN      0
`define I2CM_C2_RSEN     1
`define I2CM_C2_PEN      2
`define I2CM_C2_RCEN     3
`define I2CM_C2_ACKEN    4
`define I2CM_C2_ACKDT    5
`define I2CM_C2_ACK_RESULT_BIT  6
`define I2CM_C2_LOW_MASK 32'h0000001f

// Status register fields.
`define I2CM_ST_BF       0
`define I2CM_ST_STOP     4
`define I2CM_ST_START    3

// Event flag register fields, cleared by writing one.
`define I2CM_FL_EVENT    0
`define I2CM_FL_BCOL     1
`define I2CM_FL_WRITE_COLLISION_FLAG     2

`define I2CM_RATE_W      7
`define I2CM_RATE_RST    7'h01
`define I2CM_BITS        4'h8

`endif

//--- i2cm_pkg.sv
package i2cm_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START_WAIT, ST_START_HOLD, ST_RSTART_LOW, ST_RSTART_HIGH,
        ST_BIT_LOW, ST_BIT_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_DONE,
        ST_ACK_LOW, ST_ACK_HIGH
    } i2cm_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cm_lines_t;

endpackage : i2cm_pkg

//--- i2cm_master.sv
`timescale 1ns/10ps
`include "i2cm_cfg.svh"
// What this block does
// - Master mode needs master encoding and enable.
// - Start and stop flags clear on disable.
// - Buffer write while busy sets write collision.
// - Event flag on every condition and byte.
// - Transmit sends address then bytes, reads ack.
// - Receive clocks in bytes, sends ack.
// - Repeated start keeps the bus.
// - Ack result sampled after ninth clock.
// - Stop raises event flag when complete.
// - Reload from rate register, buffer write starts.
// - Counter counts to zero then halts.
// - Counter decrements twice per instruction cycle.
// - Operation end stops clock, SCL held.
// - One SCL period is two rollovers.
// - Counter halts while clock source sleeps.
// - High time waits for SCL seen high.
// - Start checks lines, drives SDA low.
// - Start second interval clears start enable.
// - Line low during start is bus collision.
// - Control two low bits locked during start.
// - Ack result is set on no acknowledge.
module i2cm_master #(
    parameter int RATE_W = `I2CM_RATE_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe_n,
    output logic             sda_o,
    output logic             sda_oe_n
);

    i2cm_pkg::i2cm_lines_t  meta_q;
    i2cm_pkg::i2cm_lines_t  line_q;
    i2cm_pkg::i2cm_state_t  state_q;
    logic [3:0]             mode_q;
    logic                   en_q;
    logic [5:0]             c2_q;
    logic                   ack_result_bit_q;
    logic                   start_seen_q;
    logic                   stop_seen_q;
    logic                   bf_q;
    logic                   event_q;
    logic                   bcol_q;
    logic                   write_collision_flag_q;
    logic [RATE_W-1:0]      rate_q;
    logic [RATE_W-1:0]      cnt_q;
    logic                   run_q;
    logic [7:0]             buf_q;
    logic [7:0]             shift_q;
    logic [3:0]             bit_q;
    logic                   rx_q;
    logic                   scl_low_q;
    logic                   sda_low_q;
    logic [1:0]             phase_q;

    logic master;
    logic wr;
    logic rd;
    logic busy;
    logic tick;
    logic tmo;
    logic buf_wr;
    logic buf_ok;
    logic c2_wr;
    logic fl_wr;
    logic ev_set;
    logic bc_set;
    logic ss_set;
    logic sp_set;
    logic reload;

    assign master = en_q && (mode_q == `I2CM_MODE_MASTER);
    assign wr     = psel && penable && pwrite;
    assign rd     = psel && penable && !pwrite;
    assign busy   = state_q != i2cm_pkg::ST_IDLE;
    assign buf_wr = wr && paddr == `I2CM_OFS_BUF;
    assign buf_ok = buf_wr && master && !busy && !c2_q[`I2CM_C2_SEN];
    assign c2_wr  = wr && paddr == `I2CM_OFS_CTRL2;
    assign fl_wr  = wr && paddr == `I2CM_OFS_FLAGS;
    // Second and fourth phase of a four-clock cycle; none while asleep.
    assign tick   = phase_q[0] && !sleep;
    assign tmo    = run_q && tick && cnt_q == '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '{scl: 1'b1, sda: 1'b1};
            line_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            meta_q <= '{scl: scl_i, sda: sda_i};
            line_q <= meta_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Rate counter: reload, count down to zero, then halt.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (!master) begin
            run_q <= 1'b0;
        end else if (reload) begin
            cnt_q <= rate_q;
            run_q <= 1'b1;
        end else if (tmo) begin
            run_q <= 1'b0;
        end else if (run_q && tick) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Bit engine. Each half SCL period is one rollover.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= i2cm_pkg::ST_IDLE;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            shift_q   <= 8'h00;
            bit_q     <= 4'h0;
            rx_q      <= 1'b0;
            ack_result_bit_q <= 1'b0;
        end else if (!master) begin
            state_q   <= i2cm_pkg::ST_IDLE;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            unique case (state_q)
                i2cm_pkg::ST_IDLE: begin
                    if (buf_ok) begin
                        shift_q   <= pwdata[7:0];
                        bit_q     <= 4'h0;
                        rx_q      <= 1'b0;
                        scl_low_q <= 1'b1;
                        sda_low_q <= !pwdata[7];
                        state_q   <= i2cm_pkg::ST_BIT_LOW;
                    end else if (c2_q[`I2CM_C2_SEN]) begin
                        if (!line_q.scl || !line_q.sda) begin
                            state_q <= i2cm_pkg::ST_IDLE;
                        end else begin
                            state_q <= i2cm_pkg::ST_START_WAIT;
                        end
                    end else if (c2_q[`I2CM_C2_RSEN]) begin
                        scl_low_q <= 1'b1;
                        state_q   <= i2cm_pkg::ST_RSTART_LOW;
                    end else if (c2_q[`I2CM_C2_RCEN]) begin
                        bit_q     <= 4'h0;
                        rx_q      <= 1'b1;
                        scl_low_q <= 1'b1;
                        sda_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_BIT_LOW;
                    end else if (c2_q[`I2CM_C2_ACKEN]) begin
                        scl_low_q <= 1'b1;
                        sda_low_q <= !c2_q[`I2CM_C2_ACKDT];
                        state_q   <= i2cm_pkg::ST_ACK_LOW;
                    end else if (c2_q[`I2CM_C2_PEN]) begin
                        scl_low_q <= 1'b1;
                        sda_low_q <= 1'b1;
                        state_q   <= i2cm_pkg::ST_STOP_LOW;
                    end
                end
                i2cm_pkg::ST_START_WAIT: begin
                    // A repeated start waits here for SCL to rise before
                    // counting, so low SCL is a collision only once running.
                    if (run_q && !line_q.scl) begin
                        state_q <= i2cm_pkg::ST_IDLE;
                    end else if (tmo) begin
                        sda_low_q <= 1'b1;
                        state_q   <= i2cm_pkg::ST_START_HOLD;
                    end
                end
                i2cm_pkg::ST_START_HOLD: begin
                    if (tmo) begin
                        state_q <= i2cm_pkg::ST_IDLE;
                    end
                end
                i2cm_pkg::ST_RSTART_LOW: begin
                    if (tmo) begin
                        sda_low_q <= 1'b0;
                        scl_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_START_WAIT;
                    end
                end
                i2cm_pkg::ST_BIT_LOW: begin
                    if (tmo) begin
                        scl_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_BIT_HIGH;
                    end
                end
                i2cm_pkg::ST_BIT_HIGH: begin
                    if (tmo) begin
                        scl_low_q <= 1'b1;
                        bit_q     <= bit_q + 4'h1;
                        if (bit_q == `I2CM_BITS) begin
                            if (!rx_q) begin
                                ack_result_bit_q <= line_q.sda;
                            end
                            sda_low_q <= 1'b0;
                            state_q   <= i2cm_pkg::ST_IDLE;
                        end else begin
                            shift_q <= {shift_q[6:0], line_q.sda};
                            sda_low_q <= !rx_q && bit_q < 4'h7
                                         && !shift_q[6];
                            if (rx_q && bit_q == 4'h7) begin
                                state_q <= i2cm_pkg::ST_IDLE;
                            end else begin
                                state_q <= i2cm_pkg::ST_BIT_LOW;
                            end
                        end
                    end
                end
                i2cm_pkg::ST_ACK_LOW: begin
                    if (tmo) begin
                        scl_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_ACK_HIGH;
                    end
                end
                i2cm_pkg::ST_ACK_HIGH: begin
                    if (tmo) begin
                        scl_low_q <= 1'b1;
                        state_q   <= i2cm_pkg::ST_IDLE;
                    end
                end
                i2cm_pkg::ST_STOP_LOW: begin
                    if (tmo) begin
                        scl_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_STOP_HIGH;
                    end
                end
                i2cm_pkg::ST_STOP_HIGH: begin
                    if (tmo) begin
                        sda_low_q <= 1'b0;
                        state_q   <= i2cm_pkg::ST_STOP_DONE;
                    end
                end
                i2cm_pkg::ST_STOP_DONE: begin
                    if (tmo) begin
                        state_q <= i2cm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= i2cm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Reload when a phase begins, or when released SCL is seen high.
    always_comb begin
        reload = 1'b0;
        if (buf_ok) begin
            reload = 1'b1;
        end else if (state_q == i2cm_pkg::ST_IDLE && master) begin
            reload = (c2_q[`I2CM_C2_SEN] && line_q.scl && line_q.sda)
                     || c2_q[`I2CM_C2_RSEN] || c2_q[`I2CM_C2_RCEN]
                     || c2_q[`I2CM_C2_ACKEN] || c2_q[`I2CM_C2_PEN];
        end else if (tmo && state_q != i2cm_pkg::ST_START_HOLD
                     && state_q != i2cm_pkg::ST_STOP_DONE) begin
            reload = !(state_q == i2cm_pkg::ST_BIT_HIGH
                       && (bit_q == `I2CM_BITS || (rx_q && bit_q == 4'h7)))
                     && state_q != i2cm_pkg::ST_ACK_HIGH
                     && !scl_low_q;
        end else if (!scl_low_q && !run_q && line_q.scl
                     && state_q != i2cm_pkg::ST_START_HOLD
                     && state_q != i2cm_pkg::ST_STOP_DONE) begin
            reload = 1'b1;
        end
    end

    assign ss_set = state_q == i2cm_pkg::ST_START_WAIT && tmo && line_q.scl
                    && line_q.sda;
    assign sp_set = state_q == i2cm_pkg::ST_STOP_DONE && tmo;
    assign bc_set = master && ((state_q == i2cm_pkg::ST_IDLE && !buf_ok
                    && c2_q[`I2CM_C2_SEN] && (!line_q.scl || !line_q.sda))
                    || (state_q == i2cm_pkg::ST_START_WAIT && run_q
                        && !line_q.scl));
    assign ev_set = master && tmo && (state_q == i2cm_pkg::ST_START_HOLD
                    || state_q == i2cm_pkg::ST_STOP_DONE
                    || state_q == i2cm_pkg::ST_ACK_HIGH
                    || (state_q == i2cm_pkg::ST_BIT_HIGH
                        && (bit_q == `I2CM_BITS
                            || (rx_q && bit_q == 4'h7))));

    // Start and stop seen flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
        end else if (!en_q) begin
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
        end else if (ss_set) begin
            start_seen_q <= 1'b1;
            stop_seen_q  <= 1'b0;
        end else if (sp_set) begin
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b1;
        end
    end

    // Sticky flags; a set in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_q <= 1'b0;
            bcol_q  <= 1'b0;
            write_collision_flag_q  <= 1'b0;
        end else begin
            event_q <= ev_set || (event_q
                       && !(fl_wr && pwdata[`I2CM_FL_EVENT]));
            bcol_q  <= bc_set || (bcol_q
                       && !(fl_wr && pwdata[`I2CM_FL_BCOL]));
            write_collision_flag_q  <= (buf_wr && !buf_ok) || (write_collision_flag_q
                       && !(fl_wr && pwdata[`I2CM_FL_WRITE_COLLISION_FLAG]));
        end
    end

    // Software registers and buffer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 4'h0;
            en_q   <= 1'b0;
            rate_q <= `I2CM_RATE_RST;
            c2_q   <= 6'h00;
            buf_q  <= 8'h00;
            bf_q   <= 1'b0;
        end else begin
            if (wr && paddr == `I2CM_OFS_CTRL1) begin
                mode_q <= pwdata[3:0];
                en_q   <= pwdata[`I2CM_C1_EN];
            end
            if (wr && paddr == `I2CM_OFS_RATE) begin
                rate_q <= pwdata[RATE_W-1:0];
            end
            if (!master) begin
                c2_q[4:0] <= 5'h00;
            end else if (c2_wr && !busy && !c2_q[`I2CM_C2_SEN]) begin
                c2_q <= pwdata[5:0];
            end else if (state_q != i2cm_pkg::ST_IDLE) begin
                c2_q[4:1] <= 4'h0;
                // Start enable stays visible until the start completes.
                if (bc_set || (tmo
                    && state_q == i2cm_pkg::ST_START_HOLD)) begin
                    c2_q[`I2CM_C2_SEN] <= 1'b0;
                end
            end else if (bc_set) begin
                c2_q[`I2CM_C2_SEN] <= 1'b0;
            end
            if (buf_ok) begin
                buf_q <= pwdata[7:0];
                bf_q  <= 1'b1;
            end else if (ev_set && rx_q
                         && state_q == i2cm_pkg::ST_BIT_HIGH) begin
                buf_q <= {shift_q[6:0], line_q.sda};
                bf_q  <= 1'b1;
            end else if ((rd && paddr == `I2CM_OFS_BUF)
                         || (ev_set && !rx_q)) begin
                bf_q <= 1'b0;
            end
        end
    end

    // APB read data and answer; addresses above the flag register answer with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > `I2CM_OFS_FLAGS;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `I2CM_OFS_CTRL1:  prdata <= {26'h0, en_q, 1'b0, mode_q};
                    `I2CM_OFS_CTRL2:  prdata <= {25'h0, ack_result_bit_q, c2_q};
                    `I2CM_OFS_STATUS: prdata <= {27'h0, stop_seen_q,
                                                 start_seen_q, 2'h0, bf_q};
                    `I2CM_OFS_BUF:    prdata <= {24'h0, buf_q};
                    `I2CM_OFS_RATE:   prdata <= {25'h0, rate_q};
                    `I2CM_OFS_FLAGS:  prdata <= {29'h0, write_collision_flag_q, bcol_q,
                                                 event_q};
                    default:          prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Open-drain outputs: drive zero only, enable low while pulling.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_o    <= 1'b0;
            sda_o    <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_o    <= 1'b0;
            sda_o    <= 1'b0;
            scl_oe_n <= !(master && scl_low_q);
            sda_oe_n <= !(master && sda_low_q);
        end
    end

    chk_start_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(start_seen_q) |-> $past(state_q) == i2cm_pkg::ST_START_WAIT)
        else $error("Start flag set outside start");
    chk_write_collision_flag_busy: assert property (@(posedge pclk) disable iff (!presetn)
        buf_wr && busy |=> write_collision_flag_q) else $error("Busy write lost");
    chk_disable_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !en_q |=> !start_seen_q && !stop_seen_q)
        else $error("Flags kept while off");
    chk_count_halt: assert property (@(posedge pclk) disable iff (!presetn)
        !run_q && !reload |=> $stable(cnt_q))
        else $error("Counter moved while halted");
    chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sleep && !reload |=> $stable(cnt_q))
        else $error("Counter moved in sleep");
    chk_tick_rate: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick) else $error("Tick too fast");
    chk_bcol_start: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == i2cm_pkg::ST_START_WAIT && run_q && !line_q.scl
        |=> bcol_q && state_q == i2cm_pkg::ST_IDLE)
        else $error("Collision not flagged");
    chk_drive_low: assert property (@(posedge pclk) disable iff (!presetn)
        !scl_o && !sda_o) else $error("Line driven high");

endmodule : i2cm_master

//--- i2cm_slave_model.sv
`timescale 1ns/10ps
module i2cm_slave_model (
    input  wire logic       pclk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       stretch,
    input  wire logic       hold_sda,
    output logic            scl_rel,
    output logic            sda_rel,
    output logic [7:0]      rx_byte
);
    logic [3:0] cnt;
    logic [7:0] shf;
    logic       ack_drv;
    initial begin
        cnt = 4'h0;
        shf = 8'h00;
        ack_drv = 1'b0;
        scl_rel = 1'b1;
        rx_byte = 8'h00;
    end
    assign sda_rel = !(hold_sda || ack_drv);
    // Start and Stop both restart the bit count.
    always @(sda) begin
        if (scl === 1'b1) begin
            cnt = 4'h0;
        end
    end
    always @(posedge scl) begin
        if (cnt < 4'h8) begin
            shf = {shf[6:0], sda};
        end
        cnt = cnt + 4'h1;
        if (cnt == 4'h8) begin
            rx_byte = shf;
        end
    end
    always @(negedge scl) begin
        if (cnt == 4'h8) begin
            ack_drv = ack_en;
        end else if (cnt == 4'h9) begin
            ack_drv = 1'b0;
            cnt = 4'h0;
        end
        // Holding SCL low longer than the master does tests that the high time waits for SCL seen high.
        if (stretch) begin
            scl_rel = 1'b0;
            repeat (24) @(posedge pclk);
            scl_rel = 1'b1;
        end
    end
endmodule : i2cm_slave_model

//--- tb.sv
`timescale 1ns/10ps
`include "i2cm_cfg.svh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel;
    logic        ack_en, stretch, hold_sda;
    logic [7:0]  rx_byte;
    wire         scl_w = (scl_oe_n ? 1'b1 : scl_o) & scl_rel;
    wire         sda_w = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;
    int          n_mismatch, checked, cyc;
    time         t0;
    i2cm_master i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    i2cm_slave_model i_slv (.pclk(pclk), .scl(scl_w), .sda(sda_w),
        .ack_en(ack_en), .stretch(stretch), .hold_sda(hold_sda),
        .scl_rel(scl_rel), .sda_rel(sda_rel), .rx_byte(rx_byte));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_flag(input int b);
        int i;
        for (i = 0; i < 500; i++) begin
            apb(1'b0, `I2CM_OFS_FLAGS, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        chk("flag", rd[b], 1'b1);
        apb(1'b1, `I2CM_OFS_FLAGS, 32'h00000007);
    endtask : wait_flag
    task automatic t_reset();
        chk("oe_n", {scl_oe_n, sda_oe_n}, 2'b11);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("status", rd & 32'h18, 32'h0);
        apb(1'b0, `I2CM_OFS_RATE, 32'h0);
        chk("rate", rd, 32'h00000001);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", err, 1'b1);
    endtask : t_reset
    task automatic t_start();
        apb(1'b1, `I2CM_OFS_CTRL1, 32'h00000028);
        apb(1'b1, `I2CM_OFS_RATE, 32'h00000003);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("idle", rd & 32'h18, 32'h0);
        sleep <= 1'b1;
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000001);
        apb(1'b1, `I2CM_OFS_BUF, 32'h000000a0);
        apb(1'b0, `I2CM_OFS_FLAGS, 32'h0);
        chk("write_collision_flag", rd[`I2CM_FL_WRITE_COLLISION_FLAG], 1'b1);
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000004);
        apb(1'b0, `I2CM_OFS_CTRL2, 32'h0);
        chk("ctrl2 locked", rd & `I2CM_C2_LOW_MASK, 32'h1);
        repeat (100) @(posedge pclk);
        chk("sda asleep", sda_w, 1'b1);
        sleep <= 1'b0;
        wait_flag(`I2CM_FL_EVENT);
        chk("start lines", {scl_w, sda_w}, 2'b10);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("start seen", rd[`I2CM_ST_START], 1'b1);
        apb(1'b0, `I2CM_OFS_CTRL2, 32'h0);
        chk("ctrl2 low", rd & `I2CM_C2_LOW_MASK, 32'h0);
    endtask : t_start
    task automatic t_tx(input logic [7:0] b, input logic ack, st);
        ack_en <= ack;
        stretch <= st;
        apb(1'b1, `I2CM_OFS_BUF, {24'h0, b});
        @(posedge scl_w);
        t0 = $time;
        @(negedge scl_w);
        chk("high time", ($time - t0) >= 64, 1'b1);
        @(posedge scl_w);
        if (!st) chk("period", ($time - t0) / 8 inside {[16:20]}, 1'b1);
        wait_flag(`I2CM_FL_EVENT);
        chk("scl held", scl_w, 1'b0);
        chk("rx byte", rx_byte, b);
        apb(1'b0, `I2CM_OFS_CTRL2, 32'h0);
        chk("ack result", rd[`I2CM_C2_ACK_RESULT_BIT], !ack);
        stretch <= 1'b0;
    endtask : t_tx
    task automatic t_rx();
        hold_sda <= 1'b1;
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000008);
        wait_flag(`I2CM_FL_EVENT);
        hold_sda <= 1'b0;
        apb(1'b0, `I2CM_OFS_BUF, 32'h0);
        chk("rx data", rd, 32'h00000000);
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000010);
        wait_flag(`I2CM_FL_EVENT);
        chk("ack lines", {scl_w, sda_w}, 2'b00);
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000002);
        wait_flag(`I2CM_FL_EVENT);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("restart", rd & 32'h18, 32'h00000008);
    endtask : t_rx
    task automatic t_stop();
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000004);
        wait_flag(`I2CM_FL_EVENT);
        chk("stop lines", {scl_w, sda_w, scl_o, sda_o}, 4'hc);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("stop seen", rd[`I2CM_ST_STOP], 1'b1);
    endtask : t_stop
    task automatic t_bcol();
        hold_sda <= 1'b1;
        apb(1'b1, `I2CM_OFS_CTRL2, 32'h00000001);
        wait_flag(`I2CM_FL_BCOL);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("no start", rd[`I2CM_ST_START], 1'b0);
        hold_sda <= 1'b0;
        apb(1'b1, `I2CM_OFS_CTRL1, 32'h00000000);
        apb(1'b0, `I2CM_OFS_STATUS, 32'h0);
        chk("disabled", rd & 32'h18, 32'h0);
    endtask : t_bcol
    initial begin
        {presetn, psel, penable, pwrite, sleep} = 5'b00000;
        {ack_en, stretch, hold_sda} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_mismatch = 0;
        checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_start();
        t_tx(8'ha0, 1'b1, 1'b0);
        t_tx(8'ha5, 1'b0, 1'b1);
        t_rx();
        t_stop();
        t_bcol();
        conclude();
    end
endmodule : tb
